// ==== logic/coulomb_counter_accumulator.sv ====
`timescale 1ns/10ps
`default_nettype none
module coulomb_counter_accumulator
  import coulomb_pkg::*;
#(
  parameter longint CONV_CYCLES = coulomb_pkg::CONV_CYCLES_DFLT,
  parameter logic [15:0] BACKUP_CONVS = coulomb_pkg::BACKUP_CONVS_DFLT
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic active_mode,
  input wire logic signed [15:0] adc_result,
  input wire logic signed [coulomb_pkg::TEMP_W-1:0] temperature,
  input wire logic [coulomb_pkg::GAIN_W-1:0] sense_gain_value,
  input wire logic [coulomb_pkg::TC_W-1:0] resistor_temp_coefficient,
  input wire coulomb_pkg::reg_wr_t reg_wr,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire coulomb_pkg::nv_word_t nv_restore,
  input wire logic [coulomb_pkg::GAIN_W-1:0] factory_gain_nv,
  output logic adc_offset_mode,
  output logic [7:0] rd_data,
  output logic [15:0] current,
  output logic [15:0] average_current,
  output logic [15:0] accumulated_charge,
  output logic [coulomb_pkg::ACC_FRAC_W-1:0] accumulated_charge_fraction,
  output logic [coulomb_pkg::GAIN_W-1:0] factory_gain_copy,
  output coulomb_pkg::nv_word_t nv_backup
);
  import coulomb_pkg::*;

  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CYCLES > 0 ? CONV_CNT_W'(CONV_CYCLES - 1) : '0;
  localparam int ACC_W = 16 + ACC_FRAC_W;

  // Conversion timer and scheduling state.
  logic [CONV_CNT_W-1:0] tmr_q;
  logic [CONV_CNT_W-1:0] tmr_d;
  logic conv_tick;
  logic [9:0] conv_cnt_q;
  logic [9:0] conv_cnt_d;
  conv_state_t state_q;
  conv_state_t state_d;

  // Result registers.
  logic signed [15:0] offset_q;
  logic signed [15:0] offset_d;
  logic [15:0] cur_q;
  logic [15:0] cur_d;
  logic [15:0] avg_q;
  logic [15:0] avg_d;
  logic signed [18:0] avg_sum_q;
  logic signed [18:0] avg_sum_d;
  logic [2:0] avg_cnt_q;
  logic [2:0] avg_cnt_d;

  // Accumulator, host byte staging and nonvolatile handling.
  logic [15:0] charge_q;
  logic [15:0] charge_d;
  logic [ACC_FRAC_W-1:0] frac_q;
  logic [ACC_FRAC_W-1:0] frac_d;
  logic [7:0] hi_byte_q;
  logic restored_q;
  logic [15:0] backup_cnt_q;
  logic [15:0] backup_cnt_d;
  nv_word_t nv_backup_q;
  logic [GAIN_W-1:0] factory_q;
  logic [7:0] rd_data_q;

  // Temperature compensation.
  logic signed [8:0] temp_half_q;
  logic signed [FACTOR_W-1:0] factor_q;
  logic signed [FACTOR_W-1:0] factor_d;

  // Combinational helpers.
  logic signed [8:0] temp_half;
  logic signed [9:0] temp_delta;
  logic signed [18:0] tc_term;
  logic temp_crossed;
  logic [15:0] scaled;
  logic wr_hi;
  logic wr_lo;
  logic restore_now;
  logic measuring;
  logic accumulate_en;
  logic [15:0] acc_in;
  logic [15:0] acc_add;
  logic signed [ACC_W:0] acc_sum;
  logic [ACC_W-1:0] acc_sat;
  logic avg_update;
  logic [15:0] avg_in;
  logic signed [18:0] avg_total;
  logic backup_due;

  // The timer only runs in active mode; in sleep it and every register
  // hold apart from host writes, host reads and the power-up restore, so sleep needs no separate save path.
  assign conv_tick = active_mode && (tmr_q == CONV_LAST);
  assign tmr_d = !active_mode ? tmr_q : (conv_tick ? '0 : tmr_q + 1'b1);

  // Host write decode; the low byte commits the pair staged earlier.
  assign wr_hi = reg_wr.en && (reg_wr.addr == ADDR_ACC_HI);
  assign wr_lo = reg_wr.en && (reg_wr.addr == ADDR_ACC_LO);
  assign restore_now = !restored_q && nv_restore.valid;

  // The front end shorts its input while either offset state is current.
  assign adc_offset_mode = (state_q != ST_MEASURE);
  assign measuring = (state_q == ST_MEASURE);

  // Temperature in half degrees; a change of that value is a crossing.
  assign temp_half = temperature[TEMP_W-1:2];
  assign temp_crossed = (temp_half != temp_half_q);
  assign temp_delta = 10'(temp_half) - REF_TEMP_HALF;
  // One coefficient step is about 2^-15 per degree, 2^-16 per half degree.
  assign tc_term = 19'($signed({1'b0, resistor_temp_coefficient})) * 19'(temp_delta);
  assign factor_d = (resistor_temp_coefficient == '0) ? FACTOR_UNITY :
                    (FACTOR_W'(FACTOR_UNITY) + tc_term);

  // Conversion pipeline: offset, gain, temperature, then saturation.
  current_scaler u_scaler (
    .raw(adc_result),
    .offset(offset_q),
    .gain(sense_gain_value),
    .factor(factor_q),
    .result(scaled)
  );

  // A normal conversion adds its own result; a periodic offset conversion adds the
  // previous one so the dropped sample costs almost nothing.
  assign acc_in = measuring ? scaled : cur_q;
  assign accumulate_en = conv_tick && !wr_lo && (state_q != ST_WR_OFFSET);
  // Small positive results are offset noise and would creep upward.
  assign acc_add = (!acc_in[15] && (acc_in < MIN_CHARGE_LSB)) ? '0 : acc_in;
  assign acc_sum = $signed({charge_q[15], charge_q, frac_q}) +
                   $signed({{(ACC_W-15){acc_add[15]}}, acc_add});
  // Clamp the integer part and pin the fraction to the matching end.
  assign acc_sat = (acc_sum[ACC_W] == acc_sum[ACC_W-1]) ? acc_sum[ACC_W-1:0] :
                   (acc_sum[ACC_W] ? {CUR_MIN, {ACC_FRAC_W{1'b0}}} : {CUR_MAX, FRAC_MAX});

  // Accumulator next value: power-up restore, host write, or conversion.
  always_comb
  begin
    charge_d = charge_q;
    frac_d = frac_q;
    if (restore_now)
    begin
      charge_d = nv_restore.data;
      frac_d = '0;
    end
    else if (wr_lo)
    begin
      charge_d = {hi_byte_q, reg_wr.data};
      frac_d = '0;
    end
    else if (accumulate_en)
    begin
      charge_d = acc_sat[ACC_W-1:ACC_FRAC_W];
      frac_d = acc_sat[ACC_FRAC_W-1:0];
    end
  end

  // Scheduling of sense and offset conversions.
  always_comb
  begin
    state_d = state_q;
    conv_cnt_d = conv_cnt_q;
    offset_d = offset_q;
    cur_d = cur_q;
    if (wr_lo)
    begin
      state_d = ST_WR_OFFSET;
    end
    else if (conv_tick)
    begin
      unique case (state_q)
        ST_MEASURE:
        begin
          cur_d = scaled;
          conv_cnt_d = conv_cnt_q + 1'b1;
          if (conv_cnt_q + 1'b1 == OFFSET_SLOT)
          begin
            state_d = ST_OFFSET;
          end
        end
        ST_OFFSET:
        begin
          offset_d = adc_result;
          conv_cnt_d = '0;
          state_d = ST_MEASURE;
        end
        ST_WR_OFFSET:
        begin
          offset_d = adc_result;
          conv_cnt_d = '0;
          state_d = ST_MEASURE;
        end
      endcase
    end
  end

  // Average over eight register updates; the offset slot counts with the
  // value it keeps showing, so the window stays eight conversions long.
  assign avg_update = conv_tick && !wr_lo && (state_q != ST_WR_OFFSET);
  assign avg_in = measuring ? scaled : cur_q;
  assign avg_total = avg_sum_q + 19'($signed(avg_in));
  always_comb
  begin
    avg_sum_d = avg_sum_q;
    avg_cnt_d = avg_cnt_q;
    avg_d = avg_q;
    if (avg_update)
    begin
      avg_cnt_d = avg_cnt_q + 1'b1;
      if (avg_cnt_q == AVG_LAST)
      begin
        avg_d = sat16(32'(avg_total >>> AVG_SHIFT));
        avg_sum_d = '0;
      end
      else
      begin
        avg_sum_d = avg_total;
      end
    end
  end

  // Backups start only once the restored value is in place.
  assign backup_due = restored_q && conv_tick && (backup_cnt_q == BACKUP_CONVS - 1'b1);
  assign backup_cnt_d = (!restored_q || !conv_tick) ? backup_cnt_q :
                        (backup_due ? '0 : backup_cnt_q + 1'b1);

  // Timer and scheduling registers.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tmr_q <= '0;
      conv_cnt_q <= '0;
      state_q <= ST_MEASURE;
    end
    else
    begin
      tmr_q <= tmr_d;
      conv_cnt_q <= conv_cnt_d;
      state_q <= state_d;
    end
  end

  // Result registers.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      offset_q <= '0;
      cur_q <= '0;
      avg_q <= '0;
      avg_sum_q <= '0;
      avg_cnt_q <= '0;
    end
    else
    begin
      offset_q <= offset_d;
      cur_q <= cur_d;
      avg_q <= avg_d;
      avg_sum_q <= avg_sum_d;
      avg_cnt_q <= avg_cnt_d;
    end
  end

  // Accumulator and host high byte staging.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      charge_q <= '0;
      frac_q <= '0;
      hi_byte_q <= '0;
    end
    else
    begin
      charge_q <= charge_d;
      frac_q <= frac_d;
      if (wr_hi)
      begin
        hi_byte_q <= reg_wr.data;
      end
    end
  end

  // Compensation factor moves only when the temperature crosses a
  // half-degree step; noise inside a step leaves the gain steady.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      temp_half_q <= '0;
      factor_q <= FACTOR_UNITY;
    end
    else if (active_mode && temp_crossed)
    begin
      temp_half_q <= temp_half;
      factor_q <= factor_d;
    end
  end

  // Power-up restore also captures the factory gain, which only feeds the
  // read-only copy and never the scaler.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      restored_q <= 1'b0;
      factory_q <= '0;
    end
    else if (restore_now)
    begin
      restored_q <= 1'b1;
      factory_q <= factory_gain_nv;
    end
  end

  // Periodic backup word, one cycle wide.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      backup_cnt_q <= '0;
      nv_backup_q <= '0;
    end
    else
    begin
      backup_cnt_q <= backup_cnt_d;
      nv_backup_q.valid <= backup_due;
      nv_backup_q.data <= charge_d;
    end
  end

  // Register read data; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_q <= '0;
    end
    else if (rd_en)
    begin
      rd_data_q <= (rd_addr == ADDR_ACC_HI) ? charge_q[15:8] :
                   (rd_addr == ADDR_ACC_LO) ? charge_q[7:0] : 8'h00;
    end
  end

  // Outputs, all from flip-flops.
  assign rd_data = rd_data_q;
  assign current = cur_q;
  assign average_current = avg_q;
  assign accumulated_charge = charge_q;
  assign accumulated_charge_fraction = frac_q;
  assign factory_gain_copy = factory_q;
  assign nv_backup = nv_backup_q;
endmodule
`default_nettype wire

// ==== logic/coulomb_pkg.sv ====
// Overview of operation
// - Convert current continuously only in active mode.
// - Sleep halts measurement, keeps every register.
// - Load signed result once per 3.515s conversion.
// - Current and average saturate at 7FFFh/8000h.
// - Every 28s average the last eight results.
// - Every 1024th conversion measures offset, reused 1023.
// - Offset conversion shows and accumulates previous result.
// - Scale by 11-bit gain, steps of 2^-10.
// - Factory gain copy is read-only, never used.
// - 8-bit temperature coefficient, 30.5ppm steps.
// - Zero coefficient means no temperature compensation.
// - Update compensation only on 0.5 degree crossings.
// - Accumulate each result, keep fraction read-only.
// - Accumulator clamps at 7FFFh and 8000h.
// - Skip positive results below 100 microvolts.
// - Any accumulator write clears the fraction.
// - Accumulator write forces an offset conversion.
// - Resume accumulating from second conversion after write.
// - Back accumulator up to NV, restore at power-up.
`default_nettype none
package coulomb_pkg;

  // Time base: conversion period in microseconds and the clock period.
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint CONV_TIME_US = 3515000;
  localparam longint CONV_CYCLES_DFLT = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 26;

  // Averaging window: eight conversions, about 28 s.
  localparam int AVG_SHIFT = 3;
  localparam logic [2:0] AVG_LAST = 3'h7;

  // Offset conversion slot within each run of 1024 conversions.
  localparam logic [9:0] OFFSET_SLOT = 10'h3FF;

  // Register limits and field widths.
  localparam logic [15:0] CUR_MAX = 16'h7FFF;
  localparam logic [15:0] CUR_MIN = 16'h8000;
  localparam int GAIN_W = 11;
  localparam int GAIN_FRAC = 10;
  localparam int TC_W = 8;
  localparam int TC_FRAC = 16;
  localparam int TEMP_W = 11;
  localparam int FACTOR_W = 19;
  localparam logic [FACTOR_W-1:0] FACTOR_UNITY = 19'h1_0000;
  localparam logic signed [9:0] REF_TEMP_HALF = 10'sh032;
  localparam int ACC_FRAC_W = 12;
  localparam logic [ACC_FRAC_W-1:0] FRAC_MAX = 12'hFFF;

  // Smallest charge current that is accumulated.
  localparam int MIN_CHARGE_UV = 100;
  localparam int CUR_LSB_PICO_V = 1562500;
  localparam logic [15:0] MIN_CHARGE_LSB = 16'(MIN_CHARGE_UV * 1000000 / CUR_LSB_PICO_V);

  // Byte addresses of the accumulator on the register port.
  localparam logic [7:0] ADDR_ACC_HI = 8'h10;
  localparam logic [7:0] ADDR_ACC_LO = 8'h11;

  // Conversions between nonvolatile backups.
  localparam logic [15:0] BACKUP_CONVS_DFLT = 16'h0010;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } nv_word_t;

  typedef enum logic [2:0] {
    ST_MEASURE = 3'b001,
    ST_OFFSET = 3'b010,
    ST_WR_OFFSET = 3'b100
  } conv_state_t;

  // Clamps a wide signed value into the 16-bit register range.
  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > $signed({{16{1'b0}}, CUR_MAX}))
    begin
      r = CUR_MAX;
    end
    else if (v < -$signed({{16{1'b0}}, CUR_MIN}))
    begin
      r = CUR_MIN;
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// ==== logic/current_scaler.sv ====
`timescale 1ns/10ps
`default_nettype none
module current_scaler
  import coulomb_pkg::*;
(
  input wire logic signed [15:0] raw,
  input wire logic signed [15:0] offset,
  input wire logic [coulomb_pkg::GAIN_W-1:0] gain,
  input wire logic signed [coulomb_pkg::FACTOR_W-1:0] factor,
  output logic [15:0] result
);
  logic signed [16:0] diff;
  logic signed [28:0] gained_full;
  logic signed [18:0] gained;
  logic signed [37:0] comp_full;
  logic signed [21:0] comp;

  // Offset is removed first so gain and temperature scale only real signal.
  assign diff = 17'(raw) - 17'(offset);
  // Gain is unsigned Q1.10, so 0 to 1.999 in 2^-10 steps.
  assign gained_full = 29'(diff) * 29'($signed({1'b0, gain}));
  assign gained = gained_full[GAIN_FRAC+18:GAIN_FRAC];
  // Temperature factor is Q16; unity when the coefficient is zero.
  assign comp_full = 38'(gained) * 38'(factor);
  assign comp = comp_full[TC_FRAC+21:TC_FRAC];
  // Saturate to the register range.
  assign result = sat16(32'(comp));
endmodule
`default_nettype wire

// ==== verification/coulomb_acc_checker_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module coulomb_acc_checker
  import coulomb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic active_mode,
  input wire coulomb_pkg::reg_wr_t reg_wr,
  input wire coulomb_pkg::nv_word_t nv_restore,
  input wire logic adc_offset_mode,
  input wire logic [15:0] current,
  input wire logic [15:0] accumulated_charge,
  input wire logic [coulomb_pkg::ACC_FRAC_W-1:0] accumulated_charge_fraction,
  input wire coulomb_pkg::nv_word_t nv_backup
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // A low-byte write is what commits the accumulator.
  wire lo_wr = reg_wr.en && (reg_wr.addr == ADDR_ACC_LO);
  logic wr_pend_q;
  logic restored_q;

  // Tracks the forced offset slot after a write, and whether the single restore was taken.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
      restored_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= lo_wr || (wr_pend_q && adc_offset_mode);
      restored_q <= restored_q || nv_restore.valid;
    end
  end

  property p_sleep_hold;
    !active_mode && !$past(active_mode) && !reg_wr.en && !nv_restore.valid |=>
      $stable(current) && $stable(accumulated_charge) && $stable(accumulated_charge_fraction);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("registers moved in sleep");

  property p_wr_load;
    lo_wr && $past(reg_wr.en) && ($past(reg_wr.addr) == ADDR_ACC_HI) |=>
      accumulated_charge == {$past(reg_wr.data, 2), $past(reg_wr.data)} && accumulated_charge_fraction == '0;
  endproperty
  a_wr_load: assert property (p_wr_load) else $error("accumulator write not taken");

  property p_wr_offset;
    lo_wr |=> adc_offset_mode;
  endproperty
  a_wr_offset: assert property (p_wr_offset) else $error("no offset slot after write");

  property p_resume;
    wr_pend_q && adc_offset_mode && !reg_wr.en && !nv_restore.valid |=>
      $stable(accumulated_charge) && $stable(accumulated_charge_fraction);
  endproperty
  a_resume: assert property (p_resume) else $error("accumulated during post-write slot");

  property p_offset_hold;
    adc_offset_mode |=> $stable(current);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("current moved in offset slot");

  property p_restore;
    nv_restore.valid && !restored_q && !reg_wr.en |=>
      accumulated_charge == $past(nv_restore.data) && accumulated_charge_fraction == '0;
  endproperty
  a_restore: assert property (p_restore) else $error("restore word not loaded");

  property p_bk_data;
    nv_backup.valid |-> nv_backup.data == accumulated_charge;
  endproperty
  a_bk_data: assert property (p_bk_data) else $error("backup word differs");

  property p_bk_pulse;
    nv_backup.valid |=> !nv_backup.valid;
  endproperty
  a_bk_pulse: assert property (p_bk_pulse) else $error("backup strobe too long");

  c_write: cover property (lo_wr);
  c_backup: cover property (nv_backup.valid);
  c_slot_end: cover property ($fell(adc_offset_mode));
endmodule
`default_nettype wire

// ==== verification/coulomb_counter_accumulator_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("unexpected %s exp %h got %h", nm, e, a); \
    end \
  end
module coulomb_counter_accumulator_tb_top;
  import coulomb_pkg::*;
  localparam longint CONV = 64'h0000_0000_0000_0014;
  localparam longint ACC_TOP = 64'h0000_0000_07FF_FFFF;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic active_mode = 1'b1;
  logic signed [15:0] adc_result = 16'h0000;
  logic signed [TEMP_W-1:0] temperature = 11'h0C8;
  logic [GAIN_W-1:0] sense_gain_value = 11'h400;
  logic [TC_W-1:0] resistor_temp_coefficient = 8'h00;
  nv_word_t nv_restore = '0;
  logic [GAIN_W-1:0] factory_gain_nv = 11'h3A5;
  reg_wr_t reg_wr;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic adc_offset_mode;
  logic [15:0] current;
  logic [15:0] average_current;
  logic [15:0] accumulated_charge;
  logic [ACC_FRAC_W-1:0] accumulated_charge_fraction;
  logic [GAIN_W-1:0] factory_gain_copy;
  nv_word_t nv_backup;
  int errors = 0;
  int n_checks = 0;
  longint e_acc = 0;

  coulomb_counter_accumulator #(
    .CONV_CYCLES(CONV),
    .BACKUP_CONVS(16'h0004)
  ) u_coulomb_counter_accumulator (
    .ref_clk, .arst_n, .active_mode, .adc_result, .temperature, .sense_gain_value,
    .resistor_temp_coefficient, .reg_wr, .rd_en, .rd_addr, .nv_restore, .factory_gain_nv,
    .adc_offset_mode, .rd_data, .current, .average_current, .accumulated_charge,
    .accumulated_charge_fraction, .factory_gain_copy, .nv_backup
  );

  host_model u_host_model (.ref_clk, .rd_data, .reg_wr, .rd_en, .rd_addr);

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One conversion with the word held; the charge model clamps at the register ends.
  task automatic step(input logic [15:0] adc, input logic [15:0] cur);
    adc_result = adc;
    repeat (CONV) @(negedge ref_clk);
    `CHK("current", cur, current)
    if (cur[15] || cur >= MIN_CHARGE_LSB)
    begin
      e_acc = e_acc + longint'($signed(cur));
    end
    e_acc = (e_acc > ACC_TOP) ? ACC_TOP : ((e_acc < -ACC_TOP - 1) ? -ACC_TOP - 1 : e_acc);
    `CHK("charge", e_acc[27:12], accumulated_charge)
    `CHK("fraction", e_acc[11:0], accumulated_charge_fraction)
  endtask

  // Writes the accumulator with an offset word of 5 waiting, then aligns to the slot end.
  task automatic acc_write(input logic [15:0] v);
    int n;
    adc_result = 16'h0005;
    u_host_model.wr_acc(v[15:8], v[7:0]);
    e_acc = longint'($signed(v)) <<< 12;
    `CHK("written", v, accumulated_charge)
    `CHK("cleared", 12'h000, accumulated_charge_fraction)
    `CHK("offset mode", 1'b1, adc_offset_mode)
    n = 0;
    while (adc_offset_mode !== 1'b0 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (3) @(negedge ref_clk);
    `CHK("slot ended", 1'b1, n < 40)
    `CHK("held", v, accumulated_charge)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host_model.rd(a, d);
    `CHK("read", e, d)
  endtask

  // Only the first restore counts; the factory copy arrives with it.
  task automatic t_restore();
    nv_restore = '{valid: 1'b1, data: 16'h1234};
    @(negedge ref_clk);
    nv_restore = '{valid: 1'b1, data: 16'h5555};
    @(negedge ref_clk);
    nv_restore = '0;
    `CHK("restored", 16'h1234, accumulated_charge)
    `CHK("factory copy", 11'h3A5, factory_gain_copy)
    rd_chk(8'h10, 8'h12);
    rd_chk(8'h11, 8'h34);
    rd_chk(8'h20, 8'h00);
  endtask

  // Offset, gain, charge threshold and saturation at both ends.
  task automatic t_scaling();
    acc_write(16'h0100);
    step(16'h03ED, 16'h03E8);
    sense_gain_value = 11'h200;
    step(16'h03ED, 16'h01F4);
    sense_gain_value = 11'h400;
    step(16'h0044, 16'h003F);
    step(16'h0045, 16'h0040);
    step(16'h8000, 16'h8000);
    sense_gain_value = 11'h7FF;
    step(16'h7FFF, 16'h7FFF);
    sense_gain_value = 11'h400;
  endtask

  // A coefficient change without a half-degree crossing must not move the factor.
  task automatic t_temp();
    temperature = 11'h0F0;
    step(16'h2715, 16'h2710);
    resistor_temp_coefficient = 8'h10;
    temperature = 11'h0F4;
    step(16'h2715, 16'h272A);
    temperature = 11'h0F7;
    resistor_temp_coefficient = 8'h20;
    step(16'h2715, 16'h272A);
    resistor_temp_coefficient = 8'h00;
    temperature = 11'h0C8;
    @(negedge ref_clk);
  endtask

  task automatic t_sleep();
    adc_result = 16'h07D5;
    active_mode = 1'b0;
    repeat (100) @(negedge ref_clk);
    `CHK("sleep current", 16'h272A, current)
    `CHK("sleep charge", e_acc[27:12], accumulated_charge)
    active_mode = 1'b1;
    step(16'h07D5, 16'h07D0);
  endtask

  task automatic t_average();
    for (int i = 0; i < 16; i++)
    begin
      step(16'h03ED, 16'h03E8);
    end
    `CHK("average", 16'h03E8, average_current)
  endtask

  task automatic t_clamp();
    acc_write(16'h7FFF);
    step(16'h7FFF, 16'h7FFA);
    acc_write(16'h8000);
    step(16'hFC1D, 16'hFC18);
    rd_chk(8'h10, 8'h80);
  endtask

  // Runs on to the periodic offset slot; it shows and adds the held word, and its new offset rules afterwards.
  task automatic t_slot();
    repeat (1022) step(16'h03ED, 16'h03E8);
    `CHK("periodic slot", 1'b1, adc_offset_mode)
    step(16'h0009, 16'h03E8);
    step(16'h03ED, 16'h03E4);
  endtask

  initial
  begin
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    t_restore();
    t_scaling();
    t_temp();
    t_sleep();
    t_average();
    t_clamp();
    t_slot();
    close_out();
  end

  // Cuts a hang short well past the expected run of about twenty-one thousand cycles.
  initial
  begin
    repeat (25000) @(posedge ref_clk);
    errors++;
    close_out();
  end
endmodule
bind coulomb_counter_accumulator coulomb_acc_checker u_coulomb_acc_checker (
  .ref_clk, .arst_n, .active_mode, .reg_wr, .nv_restore, .adc_offset_mode, .current,
  .accumulated_charge, .accumulated_charge_fraction, .nv_backup
);
`default_nettype wire

// ==== verification/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model
  import coulomb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] rd_data,
  output var coulomb_pkg::reg_wr_t reg_wr,
  output var logic rd_en,
  output var logic [7:0] rd_addr
);
  // Quiet port at time zero.
  initial
  begin
    reg_wr = '0;
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end

  // High byte then low byte on consecutive edges; idle fields are scrambled so nothing leans on them.
  task automatic wr_acc(input logic [7:0] hi, input logic [7:0] lo);
    @(negedge ref_clk);
    reg_wr = '{en: 1'b1, addr: ADDR_ACC_HI, data: hi};
    @(negedge ref_clk);
    reg_wr = '{en: 1'b1, addr: ADDR_ACC_LO, data: lo};
    @(negedge ref_clk);
    reg_wr = '{en: 1'b0, addr: ~ADDR_ACC_LO, data: ~lo};
  endtask

  // One read request; the byte is taken at the following falling edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge ref_clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
  endtask
endmodule
`default_nettype wire
